// ===== logic/ref_pkg.sv
package ref_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int           ADDR_W          = 12;
    localparam int           DATA_W          = 8;
    localparam logic [11:0]  ADDR_CTRL       = 12'h120;
    localparam logic [11:0]  ADDR_TS_DELAY   = 12'h123;
    localparam logic [11:0]  ADDR_SH_STATUS  = 12'h128;
    localparam logic [11:0]  ADDR_PHASE      = 12'h129;
    localparam logic [11:0]  ADDR_COUNT      = 12'h12A;
    localparam logic [11:0]  ADDR_IRQ_STAT   = 12'h12C;
    localparam logic [11:0]  ADDR_IRQ_MASK   = 12'h12D;
    localparam logic [11:0]  ADDR_SYNC_MODE  = 12'h1FF;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int           CTRL_CNT_CLR    = 6;
    localparam int           CTRL_MODE_LO    = 1;
    localparam int           MODE_W          = 2;
    localparam logic [1:0]   MODE_DISABLED   = 2'h0;
    localparam int           SYNC_TS_BIT     = 0;
    localparam int           TS_DELAY_W      = 7;
    localparam logic [6:0]   TS_DELAY_RST    = 7'h40;
    localparam logic [7:0]   CTRL_RST        = 8'h00;
    localparam logic [7:0]   STATUS_RST      = 8'h00;
    localparam int           NIB_W           = 4;
    localparam int           IRQ_W           = 2;
    localparam int           IRQ_CAPTURE     = 0;
    localparam int           IRQ_WRAP        = 1;

    // ----------------------------------------------------------------
    // capture and timing
    // ----------------------------------------------------------------
    localparam int           HIST_W          = 8;
    localparam int           EDGE_POS        = 4;
    localparam int           DELAY_DEPTH     = 128;
    localparam logic [3:0]   PHASE_STEP      = 4'h2;
    localparam int           SAMPLE_W        = 14;
    localparam logic [7:0]   COUNT_MAX       = 8'hFF;

endpackage

// ===== logic/bit_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for one asynchronous level
module bit_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;
    logic sync_ff;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ===== logic/pulse_delay_line.sv
`timescale 1ns/1ps
// delays a one-cycle pulse by a programmable number of cycles
module pulse_delay_line
    import ref_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // pulse and delay
    input  wire logic                  pulse_in,
    input  wire logic [TS_DELAY_W-1:0] delay,
    output logic                       pulse_out
);
    logic                  tap_ff [DELAY_DEPTH];
    logic                  out_ff;

    // shift chain, one stage per sample clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < DELAY_DEPTH; i++) begin
                tap_ff[i] <= 1'b0;
            end
        end else begin
            tap_ff[0] <= pulse_in;
            for (int i = 1; i < DELAY_DEPTH; i++) begin
                tap_ff[i] <= tap_ff[i-1];
            end
        end
    end

    // tap select, zero delay takes the input directly
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_ff <= 1'b0;
        end else if (delay == '0) begin
            out_ff <= pulse_in;
        end else begin
            out_ff <= tap_ff[delay - 7'h01];
        end
    end

    assign pulse_out = out_ff;
endmodule

// ===== logic/sysref_capture_monitor.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// Operation
// - timestamp delay programmable 0..127, resets 64
// - latch divider phase at capture, read-only
// - phase coded in half input-clock steps
// - eight-bit counter counts captured events
// - control bit 6 clears event counter
// - counter wraps 255 to zero
// - setup and hold nibbles, read-only, reset zero
// - timestamp mode marks sample, no divider reset
module sysref_capture_monitor
    import ref_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // reference pin and sample stream
    input  wire logic                sysref_in,
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output logic      [SAMPLE_W:0]   word_out,
    // register port
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [DATA_W-1:0]   rd_data,
    // interrupt
    output logic                     irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic                  ref_sync;
    logic [HIST_W-1:0]     hist_ff;
    logic                  cap;
    logic [7:0]            ctrl_ff;
    logic [TS_DELAY_W-1:0] delay_ff;
    logic                  ts_mode_ff;
    logic [NIB_W-1:0]      setup_ff;
    logic [NIB_W-1:0]      hold_ff;
    logic [NIB_W-1:0]      div_phase_ff;
    logic [NIB_W-1:0]      phase_ff;
    logic [7:0]            count_ff;
    logic [IRQ_W-1:0]      irq_stat_ff;
    logic [IRQ_W-1:0]      irq_mask_ff;
    logic [IRQ_W-1:0]      irq_evt;
    logic                  irq_ff;
    logic [DATA_W-1:0]     rd_data_ff;
    logic [DATA_W-1:0]     nxt_rd_data;
    logic                  mark_dly;
    logic [SAMPLE_W:0]     word_ff;
    logic                  cnt_clr;
    logic                  enabled;

    // ----------------------------------------------------------------
    // capture
    // ----------------------------------------------------------------

    // reference pin through two flip-flops
    bit_sync u_ref_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (sysref_in),
        .sync_out (ref_sync)
    );

    // sample history, newest at bit 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[HIST_W-2:0], ref_sync};
        end
    end

    assign enabled = ctrl_ff[CTRL_MODE_LO +: MODE_W] != MODE_DISABLED;
    assign cnt_clr = ctrl_ff[CTRL_CNT_CLR];
    // rising edge seen mid-history, so samples both sides are known
    assign cap     = enabled && !hist_ff[EDGE_POS] && hist_ff[EDGE_POS-1];

    // setup nibble is before the edge, hold nibble after it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            setup_ff <= '0;
            hold_ff  <= '0;
        end else if (cap) begin
            setup_ff <= hist_ff[HIST_W-1:EDGE_POS];
            hold_ff  <= hist_ff[EDGE_POS-1:0];
        end
    end

    // ----------------------------------------------------------------
    // divider phase
    // ----------------------------------------------------------------

    // divider phase in half input-clock units
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_phase_ff <= '0;
        end else if (cap && !ts_mode_ff) begin
            div_phase_ff <= '0;
        end else begin
            div_phase_ff <= div_phase_ff + PHASE_STEP;
        end
    end

    // snapshot of the divider at capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= '0;
        end else if (cap) begin
            phase_ff <= div_phase_ff;
        end
    end

    // ----------------------------------------------------------------
    // event counter
    // ----------------------------------------------------------------

    // clear dominates, otherwise count and wrap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
        end else if (cnt_clr) begin
            count_ff <= '0;
        end else if (cap) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // timestamp mark
    // ----------------------------------------------------------------

    // mark travels the programmed delay
    pulse_delay_line u_delay (
        .clk       (clk),
        .nrst      (nrst),
        .pulse_in  (cap && ts_mode_ff),
        .delay     (delay_ff),
        .pulse_out (mark_dly)
    );

    // output word carries the mark as its top bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_ff <= '0;
        end else begin
            word_ff <= {mark_dly, sample_in};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // writable registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff     <= CTRL_RST;
            delay_ff    <= TS_DELAY_RST;
            ts_mode_ff  <= 1'b0;
            irq_mask_ff <= '0;
        end else if (wr_en) begin
            unique case (addr)
                ADDR_CTRL:      ctrl_ff     <= wr_data;
                ADDR_TS_DELAY:  delay_ff    <= wr_data[TS_DELAY_W-1:0];
                ADDR_SYNC_MODE: ts_mode_ff  <= wr_data[SYNC_TS_BIT];
                ADDR_IRQ_MASK:  irq_mask_ff <= wr_data[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // events for the sticky status
    assign irq_evt = {cap && !cnt_clr && count_ff == COUNT_MAX, cap};

    // sticky status, read clears, a new event wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_ff <= '0;
        end else if (rd_en && addr == ADDR_IRQ_STAT) begin
            irq_stat_ff <= irq_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // read decode, unmapped reads give zero
    always_comb begin
        nxt_rd_data = '0;
        if (rd_en) begin
            unique case (addr)
                ADDR_CTRL:      nxt_rd_data = ctrl_ff;
                ADDR_TS_DELAY:  nxt_rd_data = {1'b0, delay_ff};
                ADDR_SH_STATUS: nxt_rd_data = {hold_ff, setup_ff};
                ADDR_PHASE:     nxt_rd_data = {4'h0, phase_ff};
                ADDR_COUNT:     nxt_rd_data = count_ff;
                ADDR_IRQ_STAT:  nxt_rd_data = {6'h00, irq_stat_ff};
                ADDR_IRQ_MASK:  nxt_rd_data = {6'h00, irq_mask_ff};
                ADDR_SYNC_MODE: nxt_rd_data = {7'h00, ts_mode_ff};
                default:        nxt_rd_data = '0;
            endcase
        end
    end

    // read data stands one cycle only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data  = rd_data_ff;
    assign irq      = irq_ff;
    assign word_out = word_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------

    delay_zero_mark_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (cap && ts_mode_ff && delay_ff == '0 && !$past(cap)) |-> ##2 word_ff[SAMPLE_W])
        else $error("mark missing two cycles after zero-delay capture");

    phase_latch_a: assert property (
        @(posedge clk) disable iff (!nrst)
        cap |=> phase_ff == $past(div_phase_ff))
        else $error("divider phase not latched at capture");

    phase_step_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 !$past(cap) |-> div_phase_ff == $past(div_phase_ff) + PHASE_STEP)
        else $error("divider phase did not advance one input clock");

    count_inc_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (cap && !cnt_clr && count_ff != COUNT_MAX) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("counter did not count a capture");

    count_clr_a: assert property (
        @(posedge clk) disable iff (!nrst)
        cnt_clr |=> count_ff == '0)
        else $error("counter not cleared by control bit");

    count_wrap_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (cap && !cnt_clr && count_ff == COUNT_MAX) |=> count_ff == '0 && irq_stat_ff[IRQ_WRAP])
        else $error("counter did not wrap to zero");

    setup_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        cap |=> {setup_ff, hold_ff} == $past(hist_ff))
        else $error("setup and hold not taken at capture");

    sync_div_reset_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (cap && !ts_mode_ff) |=> div_phase_ff == '0 ##1 !mark_dly)
        else $error("sync mode capture misbehaved");

    status_steady_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !cap |=> $stable(setup_ff) && $stable(hold_ff) && $stable(phase_ff))
        else $error("capture status changed between captures");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ##1 irq_ff == |($past(irq_stat_ff) & $past(irq_mask_ff)))
        else $error("interrupt does not follow masked status");

    rd_one_cycle_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !rd_en |=> rd_data_ff == '0)
        else $error("read data stood past its cycle");

    stat_sticky_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (irq_stat_ff[IRQ_CAPTURE] && !(rd_en && addr == ADDR_IRQ_STAT))
            |=> irq_stat_ff[IRQ_CAPTURE])
        else $error("capture status bit lost before its read");

    count_ro_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (wr_en && addr == ADDR_COUNT && !cap && !cnt_clr) |=> $stable(count_ff))
        else $error("write reached the read-only counter");

    cap_ts_c:   cover property (@(posedge clk) disable iff (!nrst) cap && ts_mode_ff);
    cap_sync_c: cover property (@(posedge clk) disable iff (!nrst) cap && !ts_mode_ff);
    wrap_c:     cover property (@(posedge clk) disable iff (!nrst) irq_stat_ff[IRQ_WRAP]);
    mark_c:     cover property (@(posedge clk) disable iff (!nrst) word_ff[SAMPLE_W]);

endmodule

// ===== test/sysref_source.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// reference source model
// ----------------------------------------------------------------
module sysref_source (
    // clock
    input  wire logic clk,
    // reference pin
    output logic      pin
);
    // pin rests low between pulses
    initial begin
        pin = 1'b0;
    end

    // one clean pulse: four low, len high, then a quiet tail
    task automatic fire(input int len);
        repeat (4) @(posedge clk);
        pin <= 1'b1;
        repeat (len) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import ref_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                clk;
    logic                nrst;
    logic                sysref_in;
    logic [SAMPLE_W-1:0] sample_in;
    logic [SAMPLE_W:0]   word_out;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wr_data;
    logic                wr_en;
    logic                rd_en;
    logic [DATA_W-1:0]   rd_data;
    logic                irq;
    logic [6:0]          dly [4];
    int                  err_count;
    int                  cmp_count;
    int                  mark_n;
    int                  n0;
    time                 t_rise;
    time                 t_mark;
    logic [SAMPLE_W-1:0] smp_q;
    logic [1:0]          up_q;

    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    sysref_capture_monitor sysref_capture_monitor_inst (
        .clk(clk), .nrst(nrst), .sysref_in(sysref_in), .sample_in(sample_in),
        .word_out(word_out), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .irq(irq)
    );
    sysref_source src_inst (
        .clk(clk),
        .pin(sysref_in)
    );

    // clock, sample stream and mark watcher
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) sample_in <= 14'($urandom);
    always @(posedge sysref_in) t_rise = $time;
    always @(posedge clk) begin
        smp_q <= sample_in;
        up_q  <= {up_q[0], nrst};
        if (up_q[1] === 1'b1) `CHK(word_out[SAMPLE_W-1:0], smp_q)
        if (word_out[SAMPLE_W] === 1'b1) begin
            mark_n++;
            t_mark = $time;
        end
    end

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read and compare the masked answer in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 `CHK(rd_data & m, e)
    endtask
    // counter is read only with the mode off, then capture re-enabled
    task automatic cnt(input logic [7:0] e);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_COUNT, e);
        wr(ADDR_CTRL, 8'h02);
    endtask
    task automatic pulse;
        src_inst.fire(4 + $urandom_range(3));
        repeat (4) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog for a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(73530));
        err_count = 0;
        cmp_count = 0;
        mark_n = 0;
        nrst = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        sample_in = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // reset values and an unmapped place
        rd(ADDR_TS_DELAY, 8'h40);
        rd(ADDR_SH_STATUS, STATUS_RST);
        rd(ADDR_PHASE, 8'h00);
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_IRQ_MASK, 8'h00);
        rd(ADDR_SYNC_MODE, 8'h00);
        rd(12'h7FF, 8'h00);
        cnt(8'h00);
        $display("test reset done");
        // delay field round trip, reserved bit and read-only write
        dly = '{7'h7F, 7'h00, 7'($urandom), 7'h40};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TS_DELAY, {1'b1, dly[i]});
            rd(ADDR_TS_DELAY, {1'b0, dly[i]});
        end
        wr(ADDR_SH_STATUS, 8'hAA);
        wr(ADDR_COUNT, 8'h5A);
        rd(ADDR_SH_STATUS, 8'h00);
        $display("test registers done");
        // edges are ignored while disabled
        wr(ADDR_CTRL, 8'h00);
        pulse();
        cnt(8'h00);
        // one capture: status, phase, masked then unmasked interrupt
        pulse();
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        rd(ADDR_SH_STATUS, 8'hF0);
        rd(ADDR_PHASE, 8'h00, 8'hF1);
        rd(ADDR_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(ADDR_IRQ_STAT, 8'h00);
        cnt(8'h01);
        repeat (20) @(posedge clk);
        rd(ADDR_SH_STATUS, 8'hF0);
        $display("test capture done");
        // clear, then run the counter round past its top
        wr(ADDR_CTRL, 8'h42);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL, 8'h02);
        repeat (255) pulse();
        cnt(COUNT_MAX);
        rd(ADDR_IRQ_STAT, 8'h01);
        pulse();
        cnt(8'h00);
        rd(ADDR_IRQ_STAT, 8'h03);
        `CHK(mark_n, 0)
        $display("test wrap done");
        // timestamp mode: one mark per capture, offset follows delay
        wr(ADDR_SYNC_MODE, 8'h01);
        rd(ADDR_SYNC_MODE, 8'h01);
        dly = '{7'h00, 7'h01, 7'($urandom_range(126, 2)), 7'h7F};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TS_DELAY, {1'b0, dly[i]});
            pulse();
            repeat (140) @(posedge clk);
            if (i == 0) n0 = int'((t_mark - t_rise) / 8);
            `CHK(int'((t_mark - t_rise) / 8) - n0, int'(dly[i]))
            `CHK(mark_n, i + 1)
        end
        $display("test timestamp done");
        end_sim();
    end
endmodule
